//--- rtl/cantmc_pkg.sv
// package for the can transceiver mode control block
package cantmc_pkg;
	// transceiver mode encodings as seen by software
	typedef enum logic [1:0] {
		CANTMC_MODE_OFF = 2'h0,
		CANTMC_MODE_WAKE = 2'h1,
		CANTMC_MODE_NORMAL = 2'h2,
		CANTMC_MODE_RXONLY = 2'h3
	} cantmc_mode_type;
	// chip operating modes
	typedef enum logic [2:0] {
		CANTMC_CHIP_NORMAL = 3'h0,
		CANTMC_CHIP_STOP = 3'h1,
		CANTMC_CHIP_SLEEP = 3'h2,
		CANTMC_CHIP_RESTART = 3'h3,
		CANTMC_CHIP_FAILSAFE = 3'h4
	} cantmc_chip_type;
	// mode request from the serial interface
	typedef struct packed {
		logic valid;
		cantmc_mode_type mode;
	} cantmc_req_type;
	// enable time in ns and derived cycle count at 200 MHz
	localparam int CANTMC_CLK_MHZ = 200;
	localparam int CANTMC_EN_TIME_NS = 1000;
	localparam int CANTMC_EN_CYCLES =
		(CANTMC_EN_TIME_NS * CANTMC_CLK_MHZ + 999) / 1000;
	// wake pattern phase limits in ns
	localparam int CANTMC_WAKE1_NS = 500;
	localparam int CANTMC_WAKE2_NS = 1000000;
	localparam int CANTMC_WAKE1_CYC =
		(CANTMC_WAKE1_NS * CANTMC_CLK_MHZ + 999) / 1000;
	localparam int CANTMC_WAKE2_CYC = CANTMC_WAKE2_NS / 1000 * CANTMC_CLK_MHZ;
	localparam int CANTMC_FIFO_DEPTH = 16;
	localparam int CANTMC_FIFO_WIDTH = 1;
endpackage

//--- rtl/cantmc_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/100ps
module cantmc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic clk, // clock
	input wire logic nrst, // async reset, active low
	input wire logic in_valid, // write request
	output logic in_ready, // space available
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // data available
	input wire logic out_ready, // read accept
	output logic [WIDTH-1:0] out_data // read data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;

	// =========================================
	// flags
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	// storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (do_rd) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			if (do_wr && !do_rd) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_rd && !do_wr) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

//--- rtl/cantmc_core.sv
// transceiver mode control, transmit gating, receive and wake logic
// =========================================
// Function
// - after reset the transceiver mode is Off until software changes it or the chip enters fail-safe
// - Off may be selected in every chip mode except fail-safe and stops all activity
// - in Off mode bus wake patterns are ignored entirely
// - Normal mode only by command and only in chip Normal mode
// - a dominant begun before delay end is never driven onto bus
// - after delay, Normal mode copies transmit input onto bus
// - in Normal and receive-only mode the received bus state appears on the receive output
// - Wake Capable mode detects a bus wake pattern and reports it
// - receive-only mode receives but never transmits
// - paths support bit rates up to 2 Mbaud
// - fd tolerant behaviour is provided by the physical layer
// - receive-only allowed in chip Normal or Stop mode
// - after wake, receive output held low until a mode change or a chip change into stop, sleep or fail-safe
// - after wake mode stays Wake Capable; rearm by mode change or chip change into stop, sleep or fail-safe
`timescale 1ns/100ps
module cantmc_core import cantmc_pkg::*; #(
	parameter int EN_CYCLES = CANTMC_EN_CYCLES,
	parameter int WAKE1_CYC = CANTMC_WAKE1_CYC,
	parameter int WAKE2_CYC = CANTMC_WAKE2_CYC,
	parameter int FIFO_DEPTH = CANTMC_FIFO_DEPTH
) (
	input wire logic clk, // 200 MHz clock
	input wire logic nrst, // async reset, active low
	input wire cantmc_chip_type chip_mode, // chip operating mode
	input wire cantmc_req_type mode_req, // mode request pulse
	output logic mode_req_refused, // request rejected, pulse
	output cantmc_mode_type mode_status, // current transceiver mode
	output logic wake_event, // wake detected, one pulse
	output logic woken, // wake latched level
	output logic tx_enabled, // enable delay elapsed
	input wire logic can_tx_input, // from protocol controller
	output logic can_rx_output, // to protocol controller
	input wire logic bus_dominant, // receiver comparator level
	output logic bus_drive_dom, // driver: drive dominant
	output logic bus_driver_en, // driver stage enabled
	output logic bus_rx_en, // receiver enabled
	output logic rx_valid, // buffered bus sample valid
	input wire logic rx_ready, // buffered sample taken
	output logic rx_data, // buffered bus sample, 1 = dominant
	output logic rx_overflow // sample lost, pulse
);
	localparam int CW = $clog2(WAKE2_CYC + 1);
	localparam int EW = $clog2(EN_CYCLES + 1);
	cantmc_mode_type mode_q;
	cantmc_chip_type chip_q;
	logic [EW-1:0] en_cnt_q;
	logic armed_q;
	logic woken_q;
	logic refused_q;
	logic wake_q;
	logic gate_q;
	logic drive_q;
	logic rx_q;
	logic ovf_q;
	logic [1:0] wph_q;
	logic [CW-1:0] wcnt_q;
	logic bus_q;
	logic accept;
	logic allowed;
	logic rearm;
	logic in_ready;

	// =========================================
	// mode selection
	always_comb begin
		unique case (mode_req.mode)
			CANTMC_MODE_OFF: allowed = 1'b1;
			CANTMC_MODE_NORMAL: allowed = (chip_mode == CANTMC_CHIP_NORMAL);
			CANTMC_MODE_RXONLY: allowed = (chip_mode == CANTMC_CHIP_NORMAL) ||
				(chip_mode == CANTMC_CHIP_STOP);
			CANTMC_MODE_WAKE: allowed = 1'b1;
		endcase
	end
	assign accept = mode_req.valid && allowed;
	// entering stop, sleep or fail-safe rearms wake
	assign rearm = (chip_mode != chip_q) && ((chip_mode == CANTMC_CHIP_STOP) ||
		(chip_mode == CANTMC_CHIP_SLEEP) || (chip_mode == CANTMC_CHIP_FAILSAFE));

	// mode register; fail-safe forces wake capable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= CANTMC_MODE_OFF;
			chip_q <= CANTMC_CHIP_NORMAL;
			refused_q <= 1'b0;
		end else begin
			chip_q <= chip_mode;
			refused_q <= mode_req.valid && !allowed;
			// an accepted request beats the automatic drop out of normal,
			// so off stays selectable in the very cycle the chip mode moves, except a move into fail-safe
			if (chip_mode == CANTMC_CHIP_FAILSAFE) begin
				mode_q <= CANTMC_MODE_WAKE;
			end else if (accept) begin
				mode_q <= mode_req.mode;
			end else if (mode_q == CANTMC_MODE_NORMAL &&
				chip_mode != CANTMC_CHIP_NORMAL) begin
				mode_q <= CANTMC_MODE_WAKE; // normal leaves with the chip mode
			end
		end
	end

	// =========================================
	// enable delay timer, restarts on every normal entry
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_cnt_q <= '0;
		end else if (mode_q != CANTMC_MODE_NORMAL ||
			(accept && mode_req.mode == CANTMC_MODE_NORMAL)) begin
			en_cnt_q <= '0;
		end else if (en_cnt_q != EW'(EN_CYCLES)) begin
			en_cnt_q <= en_cnt_q + 1'b1;
		end
	end
	assign tx_enabled = (mode_q == CANTMC_MODE_NORMAL) &&
		(en_cnt_q == EW'(EN_CYCLES));

	// transmit gating: a low running across the delay end stays blocked
	// until the input has gone recessive once, so no truncated bit leaks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			if (!tx_enabled) begin
				gate_q <= 1'b0;
			end else if (can_tx_input) begin
				gate_q <= 1'b1; // open for every later dominant bit until enable drops
			end
			drive_q <= tx_enabled && gate_q && !can_tx_input;
		end
	end
	assign bus_drive_dom = drive_q;
	assign bus_driver_en = tx_enabled; // driver off outside normal
	assign bus_rx_en = (mode_q == CANTMC_MODE_NORMAL) ||
		(mode_q == CANTMC_MODE_RXONLY);

	// =========================================
	// wake pattern: dom, rec, dom phases each within the two limits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_q <= 1'b0;
			wph_q <= 2'h0;
			wcnt_q <= '0;
			wake_q <= 1'b0;
		end else begin
			bus_q <= bus_dominant;
			wake_q <= 1'b0;
			if (mode_q != CANTMC_MODE_WAKE || !armed_q || woken_q) begin
				wph_q <= 2'h0; // off mode never detects
				wcnt_q <= '0;
			end else if (bus_q != bus_dominant) begin
				// phase ends on an edge; check its length
				wcnt_q <= '0;
				if (wcnt_q >= CW'(WAKE1_CYC) && wcnt_q < CW'(WAKE2_CYC) &&
					bus_q == (wph_q != 2'h1)) begin
					if (wph_q == 2'h2) begin
						wake_q <= 1'b1;
						wph_q <= 2'h0;
					end else begin
						wph_q <= wph_q + 1'b1;
					end
				end else begin
					wph_q <= 2'h0;
				end
			end else if (wcnt_q != CW'(WAKE2_CYC)) begin
				wcnt_q <= wcnt_q + 1'b1;
			end else begin
				wph_q <= 2'h0; // phase too long
			end
		end
	end

	// wake latch and arming
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			woken_q <= 1'b0;
			armed_q <= 1'b1;
		end else if (wake_q) begin
			woken_q <= 1'b1;
			armed_q <= 1'b0;
		end else if (rearm || (accept && mode_req.mode != CANTMC_MODE_WAKE) ||
			mode_q != CANTMC_MODE_WAKE) begin
			woken_q <= 1'b0;
			armed_q <= 1'b1;
		end
	end

	// =========================================
	// receive path; woken forces low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_q <= 1'b1;
		end else if (woken_q && mode_q == CANTMC_MODE_WAKE) begin
			rx_q <= 1'b0;
		end else if (bus_rx_en) begin
			rx_q <= !bus_dominant;
		end else begin
			rx_q <= 1'b1;
		end
	end

	// sample buffer; overflow flags lost samples when drain stalls
	cantmc_fifo #(.WIDTH(CANTMC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(bus_rx_en),
		.in_ready(in_ready),
		.in_data(bus_dominant),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= bus_rx_en && !in_ready;
		end
	end

	assign can_rx_output = rx_q;
	assign mode_status = mode_q; // reads wake while woken
	assign mode_req_refused = refused_q;
	assign wake_event = wake_q;
	assign woken = woken_q;
	assign rx_overflow = ovf_q;
endmodule

//--- testbench/cantmc_core_properties.sv
// checker for the transceiver mode control core
`timescale 1ns/100ps
module cantmc_core_properties import cantmc_pkg::*; #(
	parameter int EN_CYCLES = CANTMC_EN_CYCLES
) (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire cantmc_chip_type chip_mode, // chip mode
	input wire cantmc_req_type mode_req, // request
	input wire logic mode_req_refused, // refused
	input wire cantmc_mode_type mode_status, // mode
	input wire logic wake_event, // wake pulse
	input wire logic woken, // wake latch
	input wire logic tx_enabled, // delay done
	input wire logic can_tx_input, // tx in
	input wire logic can_rx_output, // rx out
	input wire logic bus_drive_dom, // drive
	input wire logic bus_driver_en, // driver on
	input wire logic bus_rx_en // receiver on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// cycles in normal mode, saturating so it never wraps;
	// an accepted normal request restarts it like the enable timer
	logic [15:0] en_cnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_cnt_q <= 16'h0;
		end else if (mode_status != CANTMC_MODE_NORMAL ||
			(mode_req.valid && mode_req.mode == CANTMC_MODE_NORMAL &&
			chip_mode == CANTMC_CHIP_NORMAL)) begin
			en_cnt_q <= 16'h0;
		end else if (en_cnt_q != 16'hFFFF) begin
			en_cnt_q <= en_cnt_q + 16'h1;
		end
	end
	// ==========================================
	// properties
	a_reset_off: assert property (
		$rose(nrst) |-> mode_status == CANTMC_MODE_OFF) else $error("reset");
	a_off_any: assert property (
		mode_req.valid && mode_req.mode == CANTMC_MODE_OFF &&
		chip_mode != CANTMC_CHIP_FAILSAFE |=>
		mode_status == CANTMC_MODE_OFF && !mode_req_refused) else $error("off");
	a_off_deaf: assert property (
		mode_status == CANTMC_MODE_OFF && $past(mode_status) ==
		CANTMC_MODE_OFF |-> !wake_event && !woken) else $error("off wake");
	a_norm_refuse: assert property (
		mode_req.valid && mode_req.mode == CANTMC_MODE_NORMAL &&
		chip_mode != CANTMC_CHIP_NORMAL |=> mode_req_refused &&
		mode_status != CANTMC_MODE_NORMAL) else $error("normal taken");
	a_en_early: assert property (
		tx_enabled |-> en_cnt_q >= EN_CYCLES) else $error("early");
	a_en_late: assert property (
		mode_status == CANTMC_MODE_NORMAL && en_cnt_q >= EN_CYCLES |->
		tx_enabled) else $error("late");
	a_no_early_dom: assert property (
		!tx_enabled && !$past(tx_enabled) |-> !bus_drive_dom) else $error("dom");
	a_rec_idle: assert property (
		$past(can_tx_input) |-> !bus_drive_dom) else $error("recessive");
	a_dom_follow: assert property (
		tx_enabled && can_tx_input ##1 tx_enabled && !can_tx_input |=>
		bus_drive_dom) else $error("follow");
	a_rxonly_quiet: assert property (
		mode_status == CANTMC_MODE_RXONLY |-> !bus_driver_en && bus_rx_en)
		else $error("rxonly");
	a_woken_low: assert property (
		woken && $past(woken) |-> !can_rx_output) else $error("woken rx");
	a_wake_mode: assert property (
		$rose(woken) |-> mode_status == CANTMC_MODE_WAKE) else $error("wake");
	// main scenarios reached
	c_enable: cover property ($rose(tx_enabled));
	c_wake: cover property ($rose(woken));
	c_refuse: cover property (mode_req_refused);
endmodule
bind cantmc_core cantmc_core_properties #(.EN_CYCLES(EN_CYCLES)) u_props (
	.clk, .nrst, .chip_mode, .mode_req, .mode_req_refused, .mode_status,
	.wake_event, .woken, .tx_enabled, .can_tx_input, .can_rx_output,
	.bus_drive_dom, .bus_driver_en, .bus_rx_en);

//--- testbench/cantmc_ctrl_model.sv
// behavioural protocol controller on the transmit input
`timescale 1ns/100ps
module cantmc_ctrl_model (
	input wire logic clk, // bench clock
	output logic can_tx_input // low = dominant
);
	// ==========================================
	// idle is recessive; only the bench starts a frame
	initial can_tx_input = 1'b1;
	// lsb first, one bit a cycle, then back to recessive
	task send(input logic [15:0] f);
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			can_tx_input <= f[i];
		end
		@(negedge clk);
		can_tx_input <= 1'b1;
	endtask
endmodule

//--- testbench/can_transceiver_mode_control_tb.sv
// self-checking bench for the transceiver mode control core
`timescale 1ns/100ps
module can_transceiver_mode_control_tb import cantmc_pkg::*; ;
	logic clk = 1'b0, nrst = 1'b0, tb_dom = 1'b0, rx_ready = 1'b1;
	cantmc_chip_type chip_mode = CANTMC_CHIP_NORMAL;
	cantmc_req_type mode_req = '0;
	cantmc_mode_type mode_status;
	logic mode_req_refused, wake_event, woken, tx_enabled, can_tx_input;
	logic can_rx_output, bus_dominant, bus_drive_dom, bus_driver_en;
	logic bus_rx_en, rx_valid, rx_data, rx_overflow, ref_seen;
	int err_count = 0, n_compared = 0, wk = 0, ovf = 0, ndom = 0, exp_dom;
	integer seed = 32'hED3A9B5C;
	// ==========================================
	// clock, bus loopback and event counters
	always #2.5 clk = ~clk;
	assign bus_dominant = bus_drive_dom | tb_dom;
	always @(posedge clk) begin
		wk += (wake_event === 1'b1);
		ovf += (rx_overflow === 1'b1);
		ndom += (bus_drive_dom === 1'b1);
	end
	cantmc_core #(.EN_CYCLES(8), .WAKE1_CYC(4), .WAKE2_CYC(50)) DUT (
		.clk, .nrst, .chip_mode, .mode_req, .mode_req_refused, .mode_status,
		.wake_event, .woken, .tx_enabled, .can_tx_input, .can_rx_output,
		.bus_dominant, .bus_drive_dom, .bus_driver_en, .bus_rx_en,
		.rx_valid, .rx_ready, .rx_data, .rx_overflow);
	cantmc_ctrl_model u_ctrl (.clk, .can_tx_input);
	// ==========================================
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one request pulse; the answer lands before return
	task req(input cantmc_mode_type m);
		mode_req <= '{1'b1, m};
		@(negedge clk);
		mode_req.valid <= 1'b0;
		ref_seen = mode_req_refused;
		@(negedge clk);
	endtask
	// dominant, recessive, dominant, recessive: 10 cycles each
	task wup;
		for (int i = 0; i < 4; i++) begin
			tb_dom <= (i % 2 == 0);
			repeat (10) @(negedge clk);
		end
	endtask
	function int zeros(input logic [15:0] f);
		zeros = 0;
		for (int i = 0; i < 16; i++) zeros += !f[i];
	endfunction
	task tally_and_finish;
		$display("mismatches %0d compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog: the sequence needs under 1000 cycles
	initial begin
		#50000;
		err_count++;
		tally_and_finish();
	end
	// ==========================================
	initial begin
		logic [15:0] f;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk(mode_status, CANTMC_MODE_OFF);
		wup();
		chk(wk[15:0], 16'h0);
		for (int c = 0; c < 4; c++) begin
			chip_mode <= cantmc_chip_type'(c);
			req(CANTMC_MODE_OFF);
			chk({ref_seen, mode_status}, {1'b0, CANTMC_MODE_OFF});
		end
		chip_mode <= CANTMC_CHIP_STOP;
		req(CANTMC_MODE_NORMAL);
		chk({ref_seen, mode_status}, {1'b1, CANTMC_MODE_OFF});
		req(CANTMC_MODE_RXONLY);
		chk(mode_status, CANTMC_MODE_RXONLY);
		chip_mode <= CANTMC_CHIP_SLEEP;
		req(CANTMC_MODE_OFF);
		req(CANTMC_MODE_RXONLY);
		chk({ref_seen, mode_status}, {1'b1, CANTMC_MODE_OFF});
		// early dominant straddles the enable delay, then random frames
		chip_mode <= CANTMC_CHIP_NORMAL;
		req(CANTMC_MODE_NORMAL);
		ndom = 0;
		exp_dom = 0;
		u_ctrl.send(16'h0000);
		chk(tx_enabled, 1'b1);
		for (int k = 0; k < 6; k++) begin
			f = 16'($random(seed));
			exp_dom += zeros(f);
			u_ctrl.send(f);
		end
		repeat (3) @(negedge clk);
		chk(ndom[15:0], exp_dom[15:0]);
		// chip leaving normal drops the transceiver out of normal
		chip_mode <= CANTMC_CHIP_STOP;
		repeat (2) @(negedge clk);
		chk(mode_status, CANTMC_MODE_WAKE);
		req(CANTMC_MODE_WAKE);
		wup();
		chk(wk[15:0], 16'h1);
		chk({woken, can_rx_output, mode_status}, {2'b10, CANTMC_MODE_WAKE});
		req(CANTMC_MODE_OFF);
		chk(woken, 1'b0);
		req(CANTMC_MODE_WAKE);
		wup();
		chk(wk[15:0], 16'h2);
		// no rearm without a mode toggle, then fail-safe rearms
		wup();
		chk(wk[15:0], 16'h2);
		chip_mode <= CANTMC_CHIP_FAILSAFE;
		repeat (2) @(negedge clk);
		chk({woken, mode_status}, {1'b0, CANTMC_MODE_WAKE});
		chip_mode <= CANTMC_CHIP_STOP;
		// fill the receive buffer past full, then drain it
		req(CANTMC_MODE_OFF);
		repeat (20) @(negedge clk);
		tb_dom <= 1'b1;
		rx_ready <= 1'b0;
		ovf = 0;
		req(CANTMC_MODE_RXONLY);
		repeat (24) @(negedge clk);
		chk({can_rx_output, ovf > 0}, 2'b01);
		req(CANTMC_MODE_OFF);
		rx_ready <= 1'b1;
		f = 16'h0;
		repeat (30) begin
			f += (rx_valid === 1'b1 && rx_data === 1'b1);
			@(negedge clk);
		end
		chk(f, 16'(CANTMC_FIFO_DEPTH));
		tally_and_finish();
	end
endmodule
